/* shared/qcl_regs.svh */
`ifndef QCL_REGS_SVH
`define QCL_REGS_SVH
// counter width, standard process-data layout
`define QCL_CNT_W 32
// largest count in the compact process-data layout
`define QCL_COMPACT_MAX 32'h0000ffff
// lower wrap limit after reset
`define QCL_LO_RST 32'h00000000
// upper wrap limit after reset, full counter depth
`define QCL_HI_RST 32'hffffffff
`endif

/* shared/qcl_pkg.sv */
package qcl_pkg;
  // input signal types: even values are quadrature encoders, odd ones pulse/direction
  typedef enum logic [2:0] {
    mode_enc_diff,
    mode_cnt_diff,
    mode_enc_ttl,
    mode_cnt_ttl,
    mode_enc_oc,
    mode_cnt_oc
  } qcl_mode_e;
  // preset handshake: waiting for an event, or holding done until all arms drop
  typedef enum logic {
    set_idle,
    set_held
  } qcl_set_e;
endpackage

/* shared/qcl_step_if.sv */
`timescale 1ns/10ps
`default_nettype none
// one counting step per cycle at most, from decoder to counter
interface qcl_step_if;
  logic up;  // count one forward
  logic dn;  // count one backward
  modport src (output up, output dn);
  modport dst (input up, input dn);
endinterface
`default_nettype wire

/* core/qcl_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser plus edge detection for a bundle of pins
module qcl_sync #(
  parameter int W = 5
) (
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_lvl,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] meta;   // first stage, read only by the second
  logic [W-1:0] stab;   // second stage, safe to use
  logic [W-1:0] prev;   // delayed copy for edges
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stab;
  logic [W-1:0] next_prev;

  // shift chain
  always_comb begin
    next_meta = i_pin;
    next_stab = meta;
    next_prev = stab;
  end

  // registers, cleared low so no edge fires at release
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      meta <= '0;
      stab <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stab <= next_stab;
      prev <= next_prev;
    end
  end

  assign o_lvl  = stab;
  assign o_rise = stab & ~prev;
  assign o_fall = ~stab & prev;
endmodule // qcl_sync
`default_nettype wire

/* core/qcl_dir_decode.sv */
`timescale 1ns/10ps
`default_nettype none
// turns synchronised A/B edges into forward/backward steps
module qcl_dir_decode
  import qcl_pkg::*;
(
  input  wire logic      i_mclk,
  input  wire logic      i_nrst,
  input  wire qcl_mode_e i_mode,
  input  wire logic      i_invert_direction,
  input  wire logic      i_a_lvl,
  input  wire logic      i_a_rise,
  input  wire logic      i_a_fall,
  input  wire logic      i_b_lvl,
  input  wire logic      i_b_rise,
  input  wire logic      i_b_fall,
  input  wire logic      i_b_open,
  qcl_step_if.src        stp
);
  logic pulse_mode;  // odd modes take direction from track B
  logic fwd_q;       // quadrature says forward
  logic bwd_q;       // quadrature says backward
  logic b_eff;       // open track B reads as low

  // direction decode, one step per cycle
  always_comb begin
    pulse_mode = i_mode[0];
    b_eff      = i_b_lvl & ~i_b_open;
    // A leading B: 00 10 11 01; simultaneous A and B edges are a skipped state
    fwd_q = ((i_a_rise & ~i_b_lvl) | (i_a_fall & i_b_lvl) |
             (i_b_rise & i_a_lvl) | (i_b_fall & ~i_a_lvl)) &
            ~((i_a_rise | i_a_fall) & (i_b_rise | i_b_fall));
    bwd_q = ((i_a_rise & i_b_lvl) | (i_a_fall & ~i_b_lvl) |
             (i_b_rise & ~i_a_lvl) | (i_b_fall & i_a_lvl)) &
            ~((i_a_rise | i_a_fall) & (i_b_rise | i_b_fall));
    if (pulse_mode) begin
      // rising edge of A is the count pulse
      stp.up = i_a_rise & (b_eff == i_invert_direction);
      stp.dn = i_a_rise & (b_eff != i_invert_direction);
    end else begin
      stp.up = i_invert_direction ? bwd_q : fwd_q;
      stp.dn = i_invert_direction ? fwd_q : bwd_q;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  enc_fwd_a: assert property (!pulse_mode && i_a_rise && !i_b_lvl && !i_b_rise && !i_b_fall
    |-> (stp.up != i_invert_direction) && (stp.dn == i_invert_direction))
    else $error("encoder step sense wrong for A leading B");
  enc_inv_a: assert property (!pulse_mode && i_b_rise && !i_a_lvl && !i_a_rise && !i_a_fall
    |-> (stp.dn != i_invert_direction) && (stp.up == i_invert_direction))
    else $error("encoder inversion not applied");
  pulse_dir_a: assert property (pulse_mode && i_a_rise
    |-> stp.up == ((i_b_lvl & ~i_b_open) == i_invert_direction))
    else $error("pulse mode direction wrong");
endmodule // qcl_dir_decode
`default_nettype wire

/* core/qcl_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qcl_regs.svh"
// Notes on behaviour
// - default limits wrap zero to full depth
// - limit write refused unless lower below upper
// - out-of-limit preset adopted, flag raised
// - new limits excluding count raise flag
// - wrap below lower limit sets underflow
// - underflow clears below two-thirds span point
// - wrap above upper limit sets overflow
// - overflow clears above one-third span point
// - A leading B counts forward
// - inversion swaps encoder counting sense
// - pulse mode: B low forward, inversion swaps
// - track B level reported as status
// - open B flagged in differential pulse mode
// - C rising edge loads lower limit
// - latch edge resets, polarity picks edge
// - C and latch reset never both act
// - preset from command, C or latch
module qcl_counter
  import qcl_pkg::*;
#(
  parameter int CNT_W = `QCL_CNT_W
) (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic             i_trk_a,
  input  wire logic             i_trk_b,
  input  wire logic             i_trk_c,
  input  wire logic             i_latch,
  input  wire logic             i_b_open,
  input  wire qcl_mode_e        i_mode,
  input  wire logic             i_invert_direction,
  input  wire logic             i_err_det_b,
  input  wire logic             i_compact,
  input  wire logic             i_en_c_reset,
  input  wire logic             i_en_ext_reset,
  input  wire logic             i_ext_polarity,
  input  wire logic             i_lo_wr,
  input  wire logic [CNT_W-1:0] i_lo_val,
  input  wire logic             i_hi_wr,
  input  wire logic [CNT_W-1:0] i_hi_val,
  input  wire logic [CNT_W-1:0] i_preset_val,
  input  wire logic             i_set_cmd,
  input  wire logic             i_set_on_c,
  input  wire logic             i_set_on_ext_pos,
  input  wire logic             i_set_on_ext_neg,
  output logic      [CNT_W-1:0] o_count,
  output logic      [CNT_W-1:0] o_lo,
  output logic      [CNT_W-1:0] o_hi,
  output logic                  o_underflow,
  output logic                  o_overflow,
  output logic                  o_outside_limits_flag,
  output logic                  o_track_b_level,
  output logic                  o_wire_break,
  output logic                  o_limit_reject,
  output logic                  o_set_done
);
  // span fraction for the hysteresis points, one or two thirds
  function automatic logic [CNT_W-1:0] frac3(input logic [CNT_W-1:0] span,
                                             input logic two);
    logic [CNT_W+1:0] prod;
    prod  = two ? {1'b0, span, 1'b0} : {2'b00, span};
    frac3 = CNT_W'(prod / 3);
  endfunction

  // pin bundle: a, b, c, latch, b_open
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  // pins cross into i_mclk before any edge logic sees them
  qcl_sync #(.W(5)) u_sync (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_pin  ({i_b_open, i_latch, i_trk_c, i_trk_b, i_trk_a}),
    .o_lvl  (pin_lvl),
    .o_rise (pin_rise),
    .o_fall (pin_fall)
  );

  qcl_step_if stp ();  // step carrier

  qcl_dir_decode u_dec (
    .i_mclk             (i_mclk),
    .i_nrst             (i_nrst),
    .i_mode             (i_mode),
    .i_invert_direction (i_invert_direction),
    .i_a_lvl            (pin_lvl[0]),
    .i_a_rise           (pin_rise[0]),
    .i_a_fall           (pin_fall[0]),
    .i_b_lvl            (pin_lvl[1]),
    .i_b_rise           (pin_rise[1]),
    .i_b_fall           (pin_fall[1]),
    .i_b_open           (pin_lvl[4]),
    .stp                (stp)
  );

  // ---- limit registers ----
  logic [CNT_W-1:0] lo;        // lower wrap limit, also reset value
  logic [CNT_W-1:0] hi;        // upper wrap limit as stored
  logic [CNT_W-1:0] next_lo;
  logic [CNT_W-1:0] next_hi;
  logic             next_reject;
  logic [CNT_W-1:0] cand_lo;   // limits as they would be after the write
  logic [CNT_W-1:0] cand_hi;

  // a write that breaks the order is dropped whole; old pair stays
  always_comb begin
    cand_lo     = i_lo_wr ? i_lo_val : lo;
    cand_hi     = i_hi_wr ? i_hi_val : hi;
    next_lo     = lo;
    next_hi     = hi;
    next_reject = 1'b0;
    if (i_lo_wr || i_hi_wr) begin
      if (cand_lo < cand_hi) begin
        next_lo = cand_lo;
        next_hi = cand_hi;
      end else begin
        next_reject = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      lo             <= CNT_W'(`QCL_LO_RST);
      hi             <= CNT_W'(`QCL_HI_RST);
      o_limit_reject <= 1'b0;
    end else begin
      lo             <= next_lo;
      hi             <= next_hi;
      o_limit_reject <= next_reject;
    end
  end

  // compact layout clips the upper limit to 16 bits of depth
  logic [CNT_W-1:0] eff_hi;
  logic [CNT_W-1:0] uf_thr;   // underflow clears below this
  logic [CNT_W-1:0] of_thr;   // overflow clears above this
  always_comb begin
    eff_hi = (i_compact && (hi > CNT_W'(`QCL_COMPACT_MAX))) ?
             CNT_W'(`QCL_COMPACT_MAX) : hi;
    uf_thr = CNT_W'(lo + frac3(eff_hi - lo, 1'b1));
    of_thr = CNT_W'(lo + frac3(eff_hi - lo, 1'b0));
  end

  // ---- event decode ----
  logic c_rst_ev;    // zero pulse reset
  logic ext_edge;    // latch edge of chosen polarity
  logic ext_rst_ev;  // latch reset
  logic set_ev;      // any armed preset source fired
  logic any_arm;     // some preset source still armed
  always_comb begin
    c_rst_ev   = i_en_c_reset & pin_rise[2];
    ext_edge   = i_ext_polarity ? pin_rise[3] : pin_fall[3];
    // with both enabled the zero pulse owns the reset, latch is ignored
    ext_rst_ev = i_en_ext_reset & ~i_en_c_reset & ext_edge;
    set_ev     = i_set_cmd | (i_set_on_c & pin_rise[2]) |
                 (i_set_on_ext_pos & pin_rise[3]) |
                 (i_set_on_ext_neg & pin_fall[3]);
    any_arm    = i_set_cmd | i_set_on_c | i_set_on_ext_pos | i_set_on_ext_neg;
  end

  // ---- preset handshake ----
  qcl_set_e set_st;
  qcl_set_e next_set_st;
  logic     load_ev;  // preset accepted this cycle
  // first event wins; no reload until every arm bit is dropped
  always_comb begin
    next_set_st = set_st;
    load_ev     = 1'b0;
    unique case (set_st)
      set_idle: begin
        if (set_ev) begin
          load_ev     = 1'b1;
          next_set_st = set_held;
        end
      end
      set_held: begin
        if (!any_arm) begin
          next_set_st = set_idle;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      set_st <= set_idle;
    end else begin
      set_st <= next_set_st;
    end
  end

  assign o_set_done = (set_st == set_held);

  // ---- counter and flags ----
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             uf;
  logic             of;
  logic             next_uf;
  logic             next_of;
  logic             next_oor;
  logic             uf_ev;   // wrap lower to upper
  logic             of_ev;   // wrap upper to lower

  // preset beats reset beats counting
  always_comb begin
    next_cnt = cnt;
    uf_ev    = 1'b0;
    of_ev    = 1'b0;
    if (load_ev) begin
      next_cnt = i_preset_val;
    end else if (c_rst_ev || ext_rst_ev) begin
      next_cnt = lo;
    end else if (stp.up) begin
      if (cnt >= eff_hi) begin
        next_cnt = lo;
        of_ev    = 1'b1;
      end else begin
        next_cnt = CNT_W'(cnt + 1'b1);
      end
    end else if (stp.dn) begin
      if (cnt <= lo) begin
        next_cnt = eff_hi;
        uf_ev    = 1'b1;
      end else begin
        next_cnt = CNT_W'(cnt - 1'b1);
      end
    end
    // a fresh wrap wins over the hysteretic clear in the same cycle
    next_uf  = uf_ev | (uf & ~(cnt < uf_thr));
    next_of  = of_ev | (of & ~(cnt > of_thr));
    // tracks both count and limit changes, so it also falls again
    next_oor = (next_cnt < next_lo) || (next_cnt > next_hi);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      cnt                   <= '0;
      uf                    <= 1'b0;
      of                    <= 1'b0;
      o_outside_limits_flag <= 1'b0;
      o_track_b_level       <= 1'b0;
      o_wire_break          <= 1'b0;
    end else begin
      cnt                   <= next_cnt;
      uf                    <= next_uf;
      of                    <= next_of;
      o_outside_limits_flag <= next_oor;
      o_track_b_level       <= pin_lvl[1];
      // only the differential pulse mode can tell open from low
      o_wire_break          <= (i_mode == mode_cnt_diff) & i_err_det_b & pin_lvl[4];
    end
  end

  assign o_count     = cnt;
  assign o_lo        = lo;
  assign o_hi        = hi;
  assign o_underflow = uf;
  assign o_overflow  = of;

  // ---- checks ----
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  limit_order_a: assert property (o_lo < o_hi)
    else $error("stored limits out of order");
  limit_reject_a: assert property (i_lo_wr && !i_hi_wr && (i_lo_val >= o_hi)
    |=> o_limit_reject && $stable(o_lo))
    else $error("bad lower limit write not refused");
  oor_track_a: assert property (o_outside_limits_flag ==
    ((o_count < o_lo) || (o_count > o_hi)))
    else $error("out-of-range flag disagrees with count");
  preset_load_a: assert property ((set_st == set_idle) && i_set_cmd
    |=> (o_count == $past(i_preset_val)) && o_set_done)
    else $error("preset not loaded");
  uf_wrap_a: assert property (stp.dn && !load_ev && !c_rst_ev && !ext_rst_ev && (cnt == lo)
    |=> o_underflow && (o_count == $past(eff_hi)))
    else $error("underflow wrap wrong");
  uf_clear_a: assert property (uf && !uf_ev && (cnt < uf_thr) |=> !o_underflow)
    else $error("underflow not cleared");
  of_wrap_a: assert property (stp.up && !load_ev && !c_rst_ev && !ext_rst_ev && (cnt == eff_hi)
    |=> o_overflow && (o_count == $past(lo)))
    else $error("overflow wrap wrong");
  of_clear_a: assert property (of && !of_ev && (cnt > of_thr) |=> !o_overflow)
    else $error("overflow not cleared");
  b_level_a: assert property (##1 o_track_b_level == $past(pin_lvl[1]))
    else $error("track B status stale");
  wire_break_a: assert property ((i_mode != mode_cnt_diff) || !i_err_det_b
    |=> !o_wire_break)
    else $error("wire break outside its mode");
  c_reset_a: assert property (c_rst_ev && !load_ev |=> o_count == $past(lo))
    else $error("zero pulse reset missed");
  ext_reset_a: assert property (ext_rst_ev && !load_ev |=> o_count == $past(lo))
    else $error("latch reset missed");
  reset_excl_a: assert property (!(c_rst_ev && ext_rst_ev))
    else $error("both reset sources active");

  wrap_up_c: cover property (of_ev ##1 o_overflow);
  wrap_dn_c: cover property (uf_ev ##1 o_underflow);
  preset_c: cover property (load_ev ##1 o_set_done ##[1:8] !o_set_done);
  reject_c: cover property (o_limit_reject);
endmodule // qcl_counter
`default_nettype wire

/* tb/qcl_enc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// behavioural encoder / pulse generator on the track and latch pins
module qcl_enc_model (
  input  wire logic i_mclk,
  output logic      o_trk_a,
  output logic      o_trk_b,
  output logic      o_trk_c,
  output logic      o_latch,
  output logic      o_b_open
);
  int unsigned phase;  // quadrature phase, 0..3
  // all pins quiet, open indication off
  initial begin
    o_trk_a  = 1'b0;
    o_trk_b  = 1'b0;
    o_trk_c  = 1'b0;
    o_latch  = 1'b0;
    o_b_open = 1'b0;
    phase    = 0;
  end
  // hold a level past the synchroniser and counter latency
  task automatic hold();
    repeat (5) @(posedge i_mclk);
    #1;
  endtask
  // one quadrature edge; forward has a leading b by a quarter period
  task automatic quad(input logic fwd);
    phase = fwd ? (phase + 1) % 4 : (phase + 3) % 4;
    o_trk_a = (phase == 1) || (phase == 2);
    o_trk_b = (phase >= 2);
    hold();
  endtask
  // one pulse on a, direction level on b first
  task automatic pulse(input logic b_lvl);
    o_trk_b = b_lvl;
    o_trk_a = 1'b0;
    hold();
    o_trk_a = 1'b1;
    hold();
    o_trk_a = 1'b0;
    hold();
  endtask
  // zero pulse on c, a single revolution mark
  task automatic zero_pulse();
    o_trk_c = 1'b1;
    hold();
    o_trk_c = 1'b0;
    hold();
  endtask
  // latch level, edges made by the caller
  task automatic set_latch(input logic v);
    o_latch = v;
    hold();
  endtask
  // front end reports track b as broken
  task automatic set_open(input logic v);
    o_b_open = v;
    hold();
  endtask
endmodule // qcl_enc_model
`default_nettype wire

/* tb/qcl_counter_test.sv */
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the position counter
module qcl_counter_test
  import qcl_pkg::*;
;
  logic        i_mclk, i_nrst;
  logic        i_trk_a, i_trk_b, i_trk_c, i_latch, i_b_open;
  qcl_mode_e   i_mode;
  logic        i_invert_direction, i_err_det_b, i_compact;
  logic        i_en_c_reset, i_en_ext_reset, i_ext_polarity;
  logic        i_lo_wr, i_hi_wr, i_set_cmd, i_set_on_c;
  logic        i_set_on_ext_pos, i_set_on_ext_neg;
  logic [31:0] i_lo_val, i_hi_val, i_preset_val;
  logic [31:0] o_count, o_lo, o_hi;
  logic        o_underflow, o_overflow, o_outside_limits_flag;
  logic        o_track_b_level, o_wire_break, o_limit_reject, o_set_done;
  logic        rej;     // captured reject pulse
  int          num_errors, checks_done, cycles;

  qcl_counter i_dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_trk_a(i_trk_a), .i_trk_b(i_trk_b),
    .i_trk_c(i_trk_c), .i_latch(i_latch), .i_b_open(i_b_open), .i_mode(i_mode),
    .i_invert_direction(i_invert_direction), .i_err_det_b(i_err_det_b),
    .i_compact(i_compact), .i_en_c_reset(i_en_c_reset),
    .i_en_ext_reset(i_en_ext_reset), .i_ext_polarity(i_ext_polarity),
    .i_lo_wr(i_lo_wr), .i_lo_val(i_lo_val), .i_hi_wr(i_hi_wr), .i_hi_val(i_hi_val),
    .i_preset_val(i_preset_val), .i_set_cmd(i_set_cmd), .i_set_on_c(i_set_on_c),
    .i_set_on_ext_pos(i_set_on_ext_pos), .i_set_on_ext_neg(i_set_on_ext_neg),
    .o_count(o_count), .o_lo(o_lo), .o_hi(o_hi), .o_underflow(o_underflow),
    .o_overflow(o_overflow), .o_outside_limits_flag(o_outside_limits_flag),
    .o_track_b_level(o_track_b_level), .o_wire_break(o_wire_break),
    .o_limit_reject(o_limit_reject), .o_set_done(o_set_done));
  qcl_enc_model i_enc (.i_mclk(i_mclk), .o_trk_a(i_trk_a), .o_trk_b(i_trk_b),
    .o_trk_c(i_trk_c), .o_latch(i_latch), .o_b_open(i_b_open));

  // 50 mhz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // step to just after the next rising edge
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  // limit write, reject pulse sampled one cycle on
  task automatic wr_lim(input logic hi, input logic [31:0] v);
    if (hi) begin
      i_hi_wr  = 1'b1;
      i_hi_val = v;
    end else begin
      i_lo_wr  = 1'b1;
      i_lo_val = v;
    end
    tick();
    rej     = o_limit_reject;
    i_hi_wr = 1'b0;
    i_lo_wr = 1'b0;
    tick();
  endtask
  // preset by command, then full release of the arm
  task automatic preset(input logic [31:0] v);
    i_preset_val = v;
    i_set_cmd    = 1'b1;
    tick();
    chk(o_count, v);
    chk(o_set_done, 1);
    tick();
    i_set_cmd = 1'b0;
    repeat (3) tick();
    chk(o_set_done, 0);
  endtask

  // main sequence
  initial begin
    i_nrst = 1'b0;
    i_invert_direction = 1'b0;
    i_err_det_b = 1'b0;
    i_compact = 1'b0;
    i_en_c_reset = 1'b0;
    i_en_ext_reset = 1'b0;
    i_ext_polarity = 1'b0;
    i_lo_wr = 1'b0;
    i_hi_wr = 1'b0;
    i_set_cmd = 1'b0;
    i_set_on_c = 1'b0;
    i_set_on_ext_pos = 1'b0;
    i_set_on_ext_neg = 1'b0;
    i_lo_val = 32'h00000000;
    i_hi_val = 32'h00000000;
    i_preset_val = 32'h00000000;
    i_mode = mode_enc_diff;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) tick();
    i_nrst = 1'b1;
    chk(o_count, 32'h00000000);
    chk(o_hi, 32'hffffffff);
    chk({o_lo[0], o_underflow, o_overflow, o_set_done}, 0);
    repeat (3) tick();
    // compact layout wraps at 16 bits, both ways
    i_compact = 1'b1;
    i_enc.quad(0);
    chk(o_count, 32'h0000ffff);
    chk(o_underflow, 1);
    i_enc.quad(1);
    chk(o_count, 32'h00000000);
    chk(o_overflow, 1);
    chk(o_underflow, 0);
    i_compact = 1'b0;
    i_enc.quad(0);
    chk(o_count, 32'hffffffff);
    // inversion swaps encoder sense
    i_invert_direction = 1'b1;
    i_enc.quad(1);
    chk(o_count, 32'hfffffffe);
    i_invert_direction = 1'b0;
    i_enc.quad(1);
    chk(o_count, 32'hffffffff);
    // limits: new upper limit excludes the count
    wr_lim(1, 32'd30);
    chk(o_hi, 32'd30);
    chk(o_outside_limits_flag, 1);
    wr_lim(0, 32'd30);
    chk(rej, 1);
    chk(o_lo, 32'd0);
    wr_lim(0, 32'd3);
    chk({rej, o_lo}, 32'd3);
    preset(32'd50);
    chk(o_outside_limits_flag, 1);
    preset(32'd3);
    chk(o_outside_limits_flag, 0);
    // underflow: span 27, clears below 21
    i_enc.quad(0);
    chk(o_underflow, 1);
    chk(o_count, 32'd30);
    preset(32'd21);
    chk(o_underflow, 1);
    preset(32'd20);
    chk(o_underflow, 0);
    // overflow: clears above 12
    preset(32'd30);
    i_enc.quad(1);
    chk(o_overflow, 1);
    chk(o_count, 32'd3);
    preset(32'd12);
    chk(o_overflow, 1);
    preset(32'd13);
    chk(o_overflow, 0);
    // zero pulse loads the lower limit
    i_en_c_reset = 1'b1;
    i_enc.zero_pulse();
    chk(o_count, 32'd3);
    // latch reset, rising then falling polarity
    i_en_c_reset   = 1'b0;
    i_en_ext_reset = 1'b1;
    i_ext_polarity = 1'b1;
    preset(32'd13);
    i_enc.set_latch(1);
    chk(o_count, 32'd3);
    // latch is high here; bring it low first so the fall is not the one tested
    i_ext_polarity = 1'b0;
    i_enc.set_latch(0);
    preset(32'd13);
    i_enc.set_latch(1);
    chk(o_count, 32'd13);
    i_enc.set_latch(0);
    chk(o_count, 32'd3);
    // both enabled: latch ignored, zero pulse acts
    i_en_c_reset = 1'b1;
    preset(32'd13);
    i_enc.set_latch(1);
    i_enc.set_latch(0);
    chk(o_count, 32'd13);
    i_enc.zero_pulse();
    chk(o_count, 32'd3);
    i_en_c_reset = 1'b0;
    i_en_ext_reset = 1'b0;
    // preset armed on zero pulse, then on latch rise, then on latch fall
    i_preset_val = 32'd7;
    i_set_on_c   = 1'b1;
    i_enc.zero_pulse();
    chk(o_set_done, 1);
    chk(o_count, 32'd7);
    i_set_on_c = 1'b0;
    repeat (3) tick();
    i_preset_val     = 32'd9;
    i_set_on_ext_pos = 1'b1;
    i_enc.set_latch(1);
    chk(o_set_done, 1);
    chk(o_count, 32'd9);
    i_set_on_ext_pos = 1'b0;
    i_enc.set_latch(0);
    i_preset_val     = 32'd5;
    i_set_on_ext_neg = 1'b1;
    i_enc.set_latch(1);
    chk(o_count, 32'd9);
    i_enc.set_latch(0);
    chk(o_set_done, 1);
    chk(o_count, 32'd5);
    i_set_on_ext_neg = 1'b0;
    repeat (3) tick();
    chk(o_set_done, 0);
    // pulse mode: b low forward, b high backward, inversion swaps
    i_mode = mode_cnt_ttl;
    i_enc.pulse(0);
    chk(o_count, 32'd6);
    i_enc.pulse(1);
    chk(o_count, 32'd5);
    chk(o_track_b_level, 1);
    i_invert_direction = 1'b1;
    i_enc.pulse(1);
    chk(o_count, 32'd6);
    i_enc.pulse(0);
    chk(o_count, 32'd5);
    chk(o_track_b_level, 0);
    // open b only flagged in differential pulse mode
    i_mode      = mode_cnt_diff;
    i_err_det_b = 1'b1;
    i_enc.set_open(1);
    chk(o_wire_break, 1);
    i_err_det_b = 1'b0;
    repeat (5) tick();
    chk(o_wire_break, 0);
    i_err_det_b = 1'b1;
    i_mode      = mode_enc_diff;
    repeat (5) tick();
    chk(o_wire_break, 0);
    // open b still reported: reads as low, so a pulse counts forward
    i_mode = mode_cnt_oc;
    i_invert_direction = 1'b0;
    i_enc.pulse(1);
    chk(o_count, 32'd6);
    chk(o_wire_break, 0);
    final_report();
  end
endmodule // qcl_counter_test
`default_nettype wire
